// ---- inc/ptc_pkg.sv ----
package ptc_pkg;
	localparam int unsigned CLK_HZ = 20_000_000;
	localparam int unsigned LINE_HZ_50 = 50;
	localparam int unsigned LINE_HZ_60 = 60;
	localparam int unsigned CLK_PER_CYC_50 = CLK_HZ / LINE_HZ_50;
	localparam int unsigned CLK_PER_CYC_60 = CLK_HZ / LINE_HZ_60;
	localparam logic [1:0] TRIP_QUAL_CYC = 2'h2;
	localparam logic [4:0] CLOSE_QUAL_CYC = 5'h1e;
	localparam int unsigned RESP_MAX_CYC = 5;
	localparam int unsigned ASSIST_SEC = 10;
	localparam logic [9:0] ASSIST_CYC_50 = 10'(ASSIST_SEC * LINE_HZ_50);
	localparam logic [9:0] ASSIST_CYC_60 = 10'(ASSIST_SEC * LINE_HZ_60);
	localparam logic [5:0] SEC_PER_MIN = 6'h3c;
	localparam logic [8:0] DELAY_INF = 9'h1ff;
	localparam logic [15:0] ASSIST_THR = 16'h0001;
	localparam logic [4:0] REG_CTRL = 5'h00;
	localparam logic [4:0] REG_CMD = 5'h04;
	localparam logic [4:0] REG_DELAY = 5'h08;
	localparam logic [4:0] REG_LEVEL = 5'h0c;
	localparam logic [4:0] REG_CLOSE = 5'h10;
	localparam logic [4:0] REG_PUMP = 5'h14;
	localparam logic [4:0] REG_STAT = 5'h18;
	localparam int CTRL_FREQ60 = 0;
	localparam int CTRL_WV = 1;
	localparam int CTRL_PUMP = 2;
	localparam int CTRL_EDIT = 3;
	localparam int CMD_HOLD = 0;
	localparam int CMD_RELEASE = 1;
	localparam int CMD_ASSIST = 2;
	localparam int FLT_LG = 0;
	localparam int FLT_LL = 1;
	localparam int FLT_CROSS = 2;
	localparam int FLT_SEQ = 3;
	localparam int FLT_ROLL = 4;
	localparam int FLT_DEAD = 5;
	localparam int FLT_W = 6;
	localparam logic [3:0] CTRL_RST = 4'h0;
	localparam logic [8:0] DELAY_RST = 9'h000;
	localparam logic [15:0] SENS_LVL_RST = 16'h0010;
	localparam logic [15:0] OVERCUR_RST = 16'h0100;
	localparam logic [15:0] CLOSE_THR_RST = 16'h0020;
	localparam logic [15:0] DEAD_RST = 16'h0008;
	localparam logic [4:0] PUMP_OPS_RST = 5'h05;
	localparam logic [8:0] PUMP_TIME_RST = 9'h03c;
	localparam logic [5:0] PUMP_LOCK_RST = 6'h0f;
	typedef enum logic [1:0] {PMP_IDLE, PMP_WIN, PMP_LOCK} ptc_pump_t;
endpackage

// ---- logic/ptc_tick.sv ----
module ptc_tick #(
	parameter int unsigned CYC_50 = 400000,
	parameter int unsigned CYC_60 = 333333
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic freq60_i,
	output logic cyc_tick_o,
	output logic sec_tick_o
);
	import ptc_pkg::*;
	logic [19:0] clk_cnt_ff;
	logic [5:0] cyc_cnt_ff;
	logic [19:0] clk_lim;
	logic [5:0] cyc_lim;
	assign clk_lim = freq60_i ? 20'(CYC_60 - 1) : 20'(CYC_50 - 1);
	assign cyc_lim = freq60_i ? 6'(LINE_HZ_60 - 1) : 6'(LINE_HZ_50 - 1);
	// Power cycle length follows the configured line frequency
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			clk_cnt_ff <= 20'h00000;
			cyc_tick_o <= 1'b0;
		end else if (clk_cnt_ff >= clk_lim) begin
			clk_cnt_ff <= 20'h00000;
			cyc_tick_o <= 1'b1;
		end else begin
			clk_cnt_ff <= clk_cnt_ff + 20'h00001;
			cyc_tick_o <= 1'b0;
		end
	end
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cyc_cnt_ff <= 6'h00;
			sec_tick_o <= 1'b0;
		end else begin
			sec_tick_o <= 1'b0;
			if (cyc_tick_o) begin
				if (cyc_cnt_ff >= cyc_lim) begin
					cyc_cnt_ff <= 6'h00;
					sec_tick_o <= 1'b1;
				end else begin
					cyc_cnt_ff <= cyc_cnt_ff + 6'h01;
				end
			end
		end
	end
endmodule

// ---- logic/ptc_top.sv ----
// How it works
// - Trip contact closes within five power cycles of a qualified reverse current.
// - Trip condition must persist two power cycles before it counts.
// - Sensitive mode trips on trip-region current at or above sensitive level.
// - Infinite delay setting selects insensitive mode: overcurrent level only.
// - Delay timer runs while sensitive condition holds, clears to zero when it drops.
// - Overcurrent in trip region trips instantly regardless of delay.
// - Watt-var uses the sixty-degree rotated region and the overcurrent level.
// - Remote open hold blocks all automatic trip and close operation.
// - Hold release command returns the device to automatic operation.
// - Close needs phasing voltage in close region at or above threshold.
// - Close contact closes within five power cycles of a qualified close.
// - Close condition must persist thirty power cycles before it counts.
// - Too many operations in pump window trip and lock out closing.
// - Assisted close drops threshold near zero, widens lines, ten seconds max.
// - Window end or close start restores programmed threshold and lines.
// - Assisted close only proceeds while pump protection is off.
// - Network voltage at or below dead level closes instantly.
// - Ground, line, crossed, sequence, rolled or dead phase faults block close.
// - Zero delay means no overcurrent pickup; one to 510 seconds enables it.
// - Editing inhibits trip, close and remote commands; trip indicator on.
//
// The register addresses and the Avalon-MM slave port were left to the implementer.
module ptc_top #(
	parameter int unsigned CLK_PER_CYC_50 = ptc_pkg::CLK_PER_CYC_50,
	parameter int unsigned CLK_PER_CYC_60 = ptc_pkg::CLK_PER_CYC_60
) (
	input wire logic CLK_I,
	input wire logic RST_B_I,
	input wire logic [4:0] AVS_ADDRESS_I,
	input wire logic AVS_READ_I,
	input wire logic AVS_WRITE_I,
	input wire logic [31:0] AVS_WRITEDATA_I,
	output logic [31:0] AVS_READDATA_O,
	output logic AVS_WAITREQUEST_O,
	input wire logic TRIP_REGION_I,
	input wire logic WV_REGION_I,
	input wire logic [15:0] REV_CUR_I,
	input wire logic CLOSE_REGION_I,
	input wire logic WIDE_REGION_I,
	input wire logic [15:0] PH_VOLT_I,
	input wire logic [15:0] NET_VOLT_I,
	input wire logic [ptc_pkg::FLT_W-1:0] FAULT_I,
	output logic TRIP_O,
	output logic CLOSE_O,
	output logic TRIP_IND_O
);
	import ptc_pkg::*;

	logic req, wr_en, ack_ff;
	logic [31:0] rdata;
	logic freq60_ff, wv_ff, pump_en_ff, edit_ff;
	logic [8:0] trip_delay_setting_ff;
	logic [15:0] sensitive_trip_level_ff, overcurrent_level_ff;
	logic [15:0] close_voltage_threshold_ff, dead_level_ff;
	logic [4:0] pump_ops_ff;
	logic [8:0] pump_time_ff;
	logic [5:0] pump_lock_ff;
	logic cmd_wr, hold_on, hold_off, assist_req;
	logic hold_ff, assist_ff;
	logic [9:0] assist_cnt_ff, assist_lim;
	logic cyc_tick, sec_tick;
	logic sens_met, overcur_met, wv_met, dly_zero, dly_inf, dly_done, trip_cond, trip_qual;
	logic [14:0] dly_ff, dly_lim;
	logic [1:0] trip_cnt_ff;
	logic [15:0] thr_eff;
	logic close_region, close_met, close_qual, dead_met, close_block;
	logic [4:0] close_cnt_ff;
	logic trip_nxt, close_nxt, close_rise, lock;
	ptc_pump_t pump_st_ff;
	logic [4:0] ops_cnt_ff;
	logic [8:0] pwin_ff;
	logic [11:0] plock_ff, plock_lim;

	// Avalon slave: one wait cycle, then the answer
	assign req = AVS_READ_I | AVS_WRITE_I;
	assign AVS_WAITREQUEST_O = req & ~ack_ff;
	assign wr_en = AVS_WRITE_I & ack_ff;
	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= req & ~ack_ff;
		end
	end
	always_comb begin
		rdata = 32'h00000000;
		case (AVS_ADDRESS_I)
			REG_CTRL: rdata = {28'h0000000, edit_ff, pump_en_ff, wv_ff, freq60_ff};
			REG_DELAY: rdata = {23'h000000, trip_delay_setting_ff};
			REG_LEVEL: rdata = {overcurrent_level_ff, sensitive_trip_level_ff};
			REG_CLOSE: rdata = {dead_level_ff, close_voltage_threshold_ff};
			REG_PUMP: rdata = {2'h0, pump_lock_ff, 7'h00, pump_time_ff, 3'h0, pump_ops_ff};
			REG_STAT: rdata = {19'h00000, ops_cnt_ff, 2'h0, lock, assist_ff, hold_ff, TRIP_IND_O,
				CLOSE_O, TRIP_O};
			default: rdata = 32'h00000000;
		endcase
	end
	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			AVS_READDATA_O <= 32'h00000000;
		end else if (AVS_READ_I && !ack_ff) begin
			AVS_READDATA_O <= rdata;
		end
	end
	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			{edit_ff, pump_en_ff, wv_ff, freq60_ff} <= CTRL_RST;
			trip_delay_setting_ff <= DELAY_RST;
			sensitive_trip_level_ff <= SENS_LVL_RST;
			overcurrent_level_ff <= OVERCUR_RST;
			close_voltage_threshold_ff <= CLOSE_THR_RST;
			dead_level_ff <= DEAD_RST;
			pump_ops_ff <= PUMP_OPS_RST;
			pump_time_ff <= PUMP_TIME_RST;
			pump_lock_ff <= PUMP_LOCK_RST;
		end else if (wr_en) begin
			case (AVS_ADDRESS_I)
				REG_CTRL: begin
					freq60_ff <= AVS_WRITEDATA_I[CTRL_FREQ60];
					wv_ff <= AVS_WRITEDATA_I[CTRL_WV];
					pump_en_ff <= AVS_WRITEDATA_I[CTRL_PUMP];
					edit_ff <= AVS_WRITEDATA_I[CTRL_EDIT];
				end
				REG_DELAY: trip_delay_setting_ff <= AVS_WRITEDATA_I[8:0];
				REG_LEVEL: begin
					sensitive_trip_level_ff <= AVS_WRITEDATA_I[15:0];
					overcurrent_level_ff <= AVS_WRITEDATA_I[31:16];
				end
				REG_CLOSE: begin
					close_voltage_threshold_ff <= AVS_WRITEDATA_I[15:0];
					dead_level_ff <= AVS_WRITEDATA_I[31:16];
				end
				REG_PUMP: begin
					pump_ops_ff <= AVS_WRITEDATA_I[4:0];
					pump_time_ff <= AVS_WRITEDATA_I[16:8];
					pump_lock_ff <= AVS_WRITEDATA_I[29:24];
				end
				default: ;
			endcase
		end
	end

	// Remote commands are ignored while settings are edited
	assign cmd_wr = wr_en & (AVS_ADDRESS_I == REG_CMD) & ~edit_ff;
	assign hold_on = cmd_wr & AVS_WRITEDATA_I[CMD_HOLD];
	assign hold_off = cmd_wr & AVS_WRITEDATA_I[CMD_RELEASE];
	assign assist_req = cmd_wr & AVS_WRITEDATA_I[CMD_ASSIST];
	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			hold_ff <= 1'b0;
		end else if (hold_on) begin
			hold_ff <= 1'b1;
		end else if (hold_off) begin
			hold_ff <= 1'b0;
		end
	end

	ptc_tick #(
		.CYC_50(CLK_PER_CYC_50),
		.CYC_60(CLK_PER_CYC_60)
	) u_tick (
		.clk_i(CLK_I),
		.rst_b_i(RST_B_I),
		.freq60_i(freq60_ff),
		.cyc_tick_o(cyc_tick),
		.sec_tick_o(sec_tick)
	);

	// Trip decision
	assign sens_met = TRIP_REGION_I & (REV_CUR_I >= sensitive_trip_level_ff);
	assign overcur_met = TRIP_REGION_I & (REV_CUR_I >= overcurrent_level_ff);
	assign wv_met = WV_REGION_I & (REV_CUR_I >= overcurrent_level_ff);
	assign dly_zero = trip_delay_setting_ff == 9'h000;
	assign dly_inf = trip_delay_setting_ff == DELAY_INF;
	// Delay counted in free-running power cycles, so its first cycle may be partial
	assign dly_lim = 15'(trip_delay_setting_ff) * (freq60_ff ? 15'(LINE_HZ_60) : 15'(LINE_HZ_50));
	assign dly_done = dly_ff >= dly_lim;
	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			dly_ff <= 15'h0000;
		end else if (!sens_met) begin
			dly_ff <= 15'h0000;
		end else if (cyc_tick && !dly_done) begin
			dly_ff <= dly_ff + 15'h0001;
		end
	end
	always_comb begin
		if (wv_ff) begin
			trip_cond = wv_met;
		end else if (dly_inf) begin
			trip_cond = overcur_met;
		end else if (dly_zero) begin
			trip_cond = sens_met;
		end else begin
			trip_cond = overcur_met | (sens_met & dly_done);
		end
	end
	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			trip_cnt_ff <= 2'h0;
		end else if (!trip_cond) begin
			trip_cnt_ff <= 2'h0;
		end else if (cyc_tick && !trip_qual) begin
			trip_cnt_ff <= trip_cnt_ff + 2'h1;
		end
	end
	// Ticks run free: one tick more guarantees two full cycles
	assign trip_qual = trip_cnt_ff > TRIP_QUAL_CYC;

	// Close decision, assisted close relaxes threshold and lines
	assign thr_eff = assist_ff ? ASSIST_THR : close_voltage_threshold_ff;
	assign close_region = assist_ff ? WIDE_REGION_I : CLOSE_REGION_I;
	assign close_met = close_region & (PH_VOLT_I >= thr_eff);
	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			close_cnt_ff <= 5'h00;
		end else if (!close_met) begin
			close_cnt_ff <= 5'h00;
		end else if (cyc_tick && !close_qual) begin
			close_cnt_ff <= close_cnt_ff + 5'h01;
		end
	end
	assign close_qual = close_cnt_ff > CLOSE_QUAL_CYC;
	assign dead_met = NET_VOLT_I <= dead_level_ff;
	assign close_block = (|FAULT_I) | lock | hold_ff | edit_ff | trip_nxt;
	assign close_nxt = (close_qual | dead_met) & ~close_block;
	assign close_rise = close_nxt & ~CLOSE_O;
	always_comb begin
		if (edit_ff) begin
			trip_nxt = 1'b0;
		end else if (hold_ff) begin
			trip_nxt = 1'b1;
		end else begin
			trip_nxt = trip_qual | lock;
		end
	end
	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			TRIP_O <= 1'b0;
			CLOSE_O <= 1'b0;
			TRIP_IND_O <= 1'b0;
		end else begin
			TRIP_O <= trip_nxt;
			CLOSE_O <= close_nxt;
			TRIP_IND_O <= edit_ff | trip_nxt | FAULT_I[FLT_SEQ] | FAULT_I[FLT_CROSS] | FAULT_I[FLT_ROLL];
		end
	end

	assign assist_lim = freq60_ff ? ASSIST_CYC_60 : ASSIST_CYC_50;
	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			assist_ff <= 1'b0;
			assist_cnt_ff <= 10'h000;
		end else if (assist_req && !pump_en_ff && !close_rise) begin
			assist_ff <= 1'b1;
			assist_cnt_ff <= 10'h000;
		end else if (assist_ff) begin
			if (close_rise || pump_en_ff || assist_cnt_ff >= assist_lim) begin
				assist_ff <= 1'b0;
			end else if (cyc_tick) begin
				assist_cnt_ff <= assist_cnt_ff + 10'h001;
			end
		end
	end

	// Pump protection
	assign lock = pump_st_ff == PMP_LOCK;
	assign plock_lim = 12'(pump_lock_ff) * 12'(SEC_PER_MIN);
	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			pump_st_ff <= PMP_IDLE;
			ops_cnt_ff <= 5'h00;
			pwin_ff <= 9'h000;
			plock_ff <= 12'h000;
		end else begin
			case (pump_st_ff)
				PMP_IDLE: begin
					if (pump_en_ff && close_rise) begin
						pump_st_ff <= PMP_WIN;
						ops_cnt_ff <= 5'h01;
						pwin_ff <= 9'h000;
					end
				end
				PMP_WIN: begin
					if (!pump_en_ff) begin
						pump_st_ff <= PMP_IDLE;
						ops_cnt_ff <= 5'h00;
					end else if (ops_cnt_ff >= pump_ops_ff) begin
						pump_st_ff <= PMP_LOCK;
						plock_ff <= 12'h000;
					end else if (pwin_ff >= pump_time_ff) begin
						pump_st_ff <= PMP_IDLE;
						ops_cnt_ff <= 5'h00;
					end else begin
						if (close_rise) begin
							ops_cnt_ff <= ops_cnt_ff + 5'h01;
						end
						if (sec_tick) begin
							pwin_ff <= pwin_ff + 9'h001;
						end
					end
				end
				PMP_LOCK: begin
					if (plock_ff >= plock_lim || hold_off) begin
						pump_st_ff <= PMP_IDLE;
						ops_cnt_ff <= 5'h00;
					end else if (sec_tick) begin
						plock_ff <= plock_ff + 12'h001;
					end
				end
				default: pump_st_ff <= PMP_IDLE;
			endcase
		end
	end

	default clocking @(posedge CLK_I); endclocking
	default disable iff (!RST_B_I);
	trip_resp_a: assert property (trip_qual && !edit_ff |=> TRIP_O) else $error("trip late");
	trip_qual_a: assert property ($rose(TRIP_O) && !$past(hold_ff) && !$past(lock)
		|-> $past(trip_cnt_ff) == 2'h3) else $error("trip unqualified");
	sens_mode_a: assert property (trip_cond && dly_zero && !wv_ff |-> sens_met)
		else $error("sensitive mode wrong");
	insens_mode_a: assert property (trip_cond && dly_inf && !wv_ff |-> REV_CUR_I >= overcurrent_level_ff)
		else $error("insensitive mode wrong");
	delay_stop_a: assert property (!sens_met |=> dly_ff == 15'h0000) else $error("delay not stopped");
	overcur_inst_a: assert property (overcur_met && !dly_zero && !wv_ff |-> trip_cond)
		else $error("no instant trip");
	hold_block_a: assert property (hold_ff && !edit_ff |=> TRIP_O && !CLOSE_O) else $error("hold ignored");
	close_qual_a: assert property ($rose(CLOSE_O) && !$past(dead_met) |-> $past(close_cnt_ff) == 5'h1f)
		else $error("close unqualified");
	fault_block_a: assert property (|FAULT_I |=> !CLOSE_O) else $error("close on fault");
	edit_inhibit_a: assert property (edit_ff |=> !TRIP_O && !CLOSE_O && TRIP_IND_O)
		else $error("edit not inhibiting");
	assist_end_a: assert property (assist_ff && close_rise |=> !assist_ff) else $error("assist kept");
	lock_block_a: assert property (lock |=> !CLOSE_O) else $error("close in lockout");
	trip_seen_c: cover property ($rose(TRIP_O) && !hold_ff);
	close_seen_c: cover property ($rose(CLOSE_O) && $past(assist_ff));
	lock_seen_c: cover property ($rose(lock));
	dly_trip_c: cover property ($rose(TRIP_O) && !dly_zero && !overcur_met && !wv_ff);
endmodule

// ---- tb/ptc_breaker.sv ----
module ptc_breaker (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic trip_i,
	input wire logic close_i,
	output logic closed_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Trip coil wins over close coil, as on the real mechanism
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) closed_o <= 1'b0;
		else if (trip_i) closed_o <= 1'b0;
		else if (close_i) closed_o <= 1'b1;
	end
endmodule

// ---- tb/ptc_top_tb.sv ----
module ptc_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import ptc_pkg::*;
	localparam int P = 20;
	logic CLK_I = 1'b0, RST_B_I = 1'b0;
	logic [4:0] AVS_ADDRESS_I = 5'h00;
	logic AVS_READ_I = 1'b0, AVS_WRITE_I = 1'b0;
	logic [31:0] AVS_WRITEDATA_I = 32'h0, AVS_READDATA_O;
	logic AVS_WAITREQUEST_O, TRIP_O, CLOSE_O, TRIP_IND_O, brk_closed;
	logic TRIP_REGION_I = 1'b0, WV_REGION_I = 1'b0, CLOSE_REGION_I = 1'b0, WIDE_REGION_I = 1'b0;
	logic [15:0] REV_CUR_I = 16'h0, PH_VOLT_I = 16'h0, NET_VOLT_I = 16'h0100;
	logic [FLT_W-1:0] FAULT_I = '0;
	logic [31:0] exp_q[$];
	int bad_count = 0, checked = 0, cyc_cnt = 0, fq;
	ptc_top #(.CLK_PER_CYC_50(P), .CLK_PER_CYC_60(16)) dut_u (.CLK_I(CLK_I), .RST_B_I(RST_B_I),
		.AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
		.AVS_WRITEDATA_I(AVS_WRITEDATA_I), .AVS_READDATA_O(AVS_READDATA_O), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
		.TRIP_REGION_I(TRIP_REGION_I), .WV_REGION_I(WV_REGION_I), .REV_CUR_I(REV_CUR_I),
		.CLOSE_REGION_I(CLOSE_REGION_I), .WIDE_REGION_I(WIDE_REGION_I), .PH_VOLT_I(PH_VOLT_I),
		.NET_VOLT_I(NET_VOLT_I), .FAULT_I(FAULT_I), .TRIP_O(TRIP_O), .CLOSE_O(CLOSE_O), .TRIP_IND_O(TRIP_IND_O));
	ptc_breaker brk_u (.clk_i(CLK_I), .rst_b_i(RST_B_I), .trip_i(TRIP_O), .close_i(CLOSE_O), .closed_o(brk_closed));
	initial begin
		forever #25 CLK_I = ~CLK_I;
	end
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	always @(posedge CLK_I) begin
		cyc_cnt++;
		if (cyc_cnt == 60000) begin
			bad_count++;
			close_out();
		end
	end
	// Watcher: each completed read pairs with the oldest note
	always @(posedge CLK_I) begin
		if (AVS_READ_I === 1'b1 && AVS_WAITREQUEST_O === 1'b0 && exp_q.size() > 0) begin
			check("readdata", AVS_READDATA_O, exp_q.pop_front());
		end
	end
	task automatic bus(input logic rd, input logic [4:0] a, input logic [31:0] d);
		@(posedge CLK_I);
		AVS_ADDRESS_I <= a;
		AVS_WRITEDATA_I <= d;
		if (rd) AVS_READ_I <= 1'b1;
		else AVS_WRITE_I <= 1'b1;
		do @(posedge CLK_I); while (AVS_WAITREQUEST_O !== 1'b0);
		AVS_READ_I <= 1'b0;
		AVS_WRITE_I <= 1'b0;
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		bus(1'b0, a, d);
	endtask
	task automatic rd(input logic [4:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus(1'b1, a, 32'h0);
	endtask
	function automatic logic pick(input int w);
		return (w == 0) ? TRIP_O : (w == 1) ? CLOSE_O : TRIP_IND_O;
	endfunction
	// Clocks until the output reaches v must fall in lo..hi
	task automatic wait_lvl(input int w, input logic v, input int lo, input int hi, input string name);
		int n;
		n = 0;
		while (pick(w) !== v && n <= hi) begin
			@(posedge CLK_I);
			n++;
		end
		check(name, 32'(n >= lo && n <= hi), 32'h1);
	endtask
	// Output must stay at v for n clocks
	task automatic hold_lvl(input int w, input logic v, input int n, input string name);
		int ok;
		ok = 1;
		repeat (n) begin
			@(posedge CLK_I);
			if (pick(w) !== v) ok = 0;
		end
		check(name, 32'(ok), 32'h1);
	endtask
	task automatic idle();
		@(posedge CLK_I);
		TRIP_REGION_I <= 1'b0;
		WV_REGION_I <= 1'b0;
		REV_CUR_I <= 16'h0;
		CLOSE_REGION_I <= 1'b0;
		WIDE_REGION_I <= 1'b0;
		PH_VOLT_I <= 16'h0;
		NET_VOLT_I <= 16'h0100;
		FAULT_I <= '0;
		repeat (3) @(posedge CLK_I);
	endtask
	task automatic trip_on(input logic wv, input logic [15:0] cur);
		@(posedge CLK_I);
		TRIP_REGION_I <= ~wv;
		WV_REGION_I <= wv;
		REV_CUR_I <= cur;
	endtask
	initial begin
		void'($urandom(10979));
		repeat (6) @(posedge CLK_I);
		RST_B_I <= 1'b1;
		rd(REG_CTRL, 32'h0);
		rd(REG_DELAY, 32'h0);
		rd(REG_LEVEL, {OVERCUR_RST, SENS_LVL_RST});
		rd(REG_CLOSE, {DEAD_RST, CLOSE_THR_RST});
		rd(REG_STAT, 32'h0);
		rd(REG_PUMP, {2'h0, PUMP_LOCK_RST, 7'h0, PUMP_TIME_RST, 3'h0, PUMP_OPS_RST});
		rd(REG_CMD, 32'h0);
		rd(5'h1c, 32'h0);
		wr(5'h1c, 32'hffffffff);
		rd(5'h1c, 32'h0);
		for (fq = 0; fq < 2; fq++) begin
			wr(REG_CTRL, 32'(fq));
			trip_on(1'b0, SENS_LVL_RST - 16'h1);
			hold_lvl(0, 1'b0, 5 * P, "trip_below");
			trip_on(1'b0, SENS_LVL_RST + 16'($urandom % 240));
			wait_lvl(0, 1'b1, (fq ? 16 : P) - 2, (fq ? 16 : P) * 5, "trip_sens");
			check("trip_ind", 32'(TRIP_IND_O), 32'h1);
			idle();
			check("trip_drop", 32'(TRIP_O), 32'h0);
		end
		wr(REG_CTRL, 32'h0);
		wr(REG_DELAY, {23'h0, DELAY_INF});
		trip_on(1'b0, 16'h0080);
		hold_lvl(0, 1'b0, 5 * P, "insens_low");
		trip_on(1'b0, OVERCUR_RST);
		wait_lvl(0, 1'b1, P - 2, 5 * P, "insens_oc");
		idle();
		wr(REG_DELAY, 32'h1);
		trip_on(1'b0, OVERCUR_RST + 16'($urandom % 256));
		wait_lvl(0, 1'b1, P - 2, 5 * P, "oc_instant");
		idle();
		trip_on(1'b0, 16'h0040);
		wait_lvl(0, 1'b1, 49 * P, 57 * P, "delay_trip");
		idle();
		wr(REG_DELAY, 32'h0);
		wr(REG_CTRL, 32'h2);
		trip_on(1'b0, OVERCUR_RST);
		hold_lvl(0, 1'b0, 5 * P, "wv_plain_region");
		trip_on(1'b1, OVERCUR_RST);
		wait_lvl(0, 1'b1, P - 2, 5 * P, "wv_trip");
		idle();
		wr(REG_CTRL, 32'h0);
		@(posedge CLK_I);
		CLOSE_REGION_I <= 1'b1;
		PH_VOLT_I <= CLOSE_THR_RST;
		wait_lvl(1, 1'b1, 29 * P, 35 * P, "auto_close");
		@(posedge CLK_I);
		check("breaker_closed", 32'(brk_closed), 32'h1);
		idle();
		check("close_drop", 32'(CLOSE_O), 32'h0);
		NET_VOLT_I <= DEAD_RST;
		wait_lvl(1, 1'b1, 0, 3, "dead_close");
		for (int f = 0; f < FLT_W; f++) begin
			@(posedge CLK_I);
			FAULT_I <= FLT_W'(1 << f);
			wait_lvl(1, 1'b0, 0, 3, "fault_drop");
			hold_lvl(1, 1'b0, 6, "fault_block");
			FAULT_I <= '0;
			wait_lvl(1, 1'b1, 0, 3, "fault_clear");
		end
		wr(REG_CMD, 32'h1);
		wait_lvl(0, 1'b1, 0, 4, "hold_trip");
		hold_lvl(1, 1'b0, 6, "hold_no_close");
		wr(REG_CMD, 32'h2);
		wait_lvl(1, 1'b1, 0, 4, "release_close");
		check("release_trip", 32'(TRIP_O), 32'h0);
		wr(REG_CTRL, 32'h8);
		wait_lvl(2, 1'b1, 0, 4, "edit_ind");
		hold_lvl(1, 1'b0, 4, "edit_no_close");
		check("edit_no_trip", 32'(TRIP_O), 32'h0);
		wr(REG_CMD, 32'h1);
		hold_lvl(0, 1'b0, 4, "edit_cmd_refused");
		rd(REG_STAT, 32'h4);
		wr(REG_CTRL, 32'h0);
		wait_lvl(1, 1'b1, 0, 4, "edit_done");
		idle();
		wr(REG_CTRL, 32'h0);
		@(posedge CLK_I);
		WIDE_REGION_I <= 1'b1;
		PH_VOLT_I <= 16'h0002;
		wr(REG_CMD, 32'h4);
		wait_lvl(1, 1'b1, 27 * P, 35 * P, "assist_close");
		wait_lvl(1, 1'b0, 0, 4, "assist_restore");
		idle();
		wr(REG_PUMP, 32'h0f003c02);
		wr(REG_CTRL, 32'h4);
		repeat (2) begin
			NET_VOLT_I <= DEAD_RST;
			wait_lvl(1, 1'b1, 0, 3, "pump_op");
			idle();
		end
		NET_VOLT_I <= DEAD_RST;
		wait_lvl(0, 1'b1, 0, 4, "pump_lock_trip");
		hold_lvl(1, 1'b0, 6, "pump_lock_open");
		wr(REG_CMD, 32'h2);
		wait_lvl(0, 1'b0, 0, 4, "pump_cleared");
		idle();
		close_out();
	end
endmodule
